// ---- pac_defs.svh ----
// Purpose: constants of the axis command unit
// Assumes: APB byte offsets, 32-bit words
// Notes: included by bare name
`ifndef PAC_DEFS_SVH
`define PAC_DEFS_SVH
// register byte offsets
`define PAC_A_CMD 8'h00
`define PAC_A_DATA 8'h04
`define PAC_A_RES 8'h08
`define PAC_A_CYC 8'h0c
`define PAC_A_CFG 8'h10
// command word fields
`define PAC_F_OP 0
`define PAC_F_AX 4
`define PAC_F_FLG 8
// config word fields
`define PAC_F_ACT 0
`define PAC_F_AUX 8
`define PAC_F_SPO 16
`define PAC_F_SPM 24
// opcodes
`define PAC_OP_START 3'h0
`define PAC_OP_STOP 3'h1
`define PAC_OP_STAT 3'h2
`define PAC_OP_REF 3'h3
`define PAC_OP_OVR 3'h4
`define PAC_OP_ANA 3'h5
// result codes
`define PAC_C_OK 3'h0
`define PAC_C_NOAX 3'h1
`define PAC_C_NOCFG 3'h2
`define PAC_C_STATE 3'h3
`define PAC_C_BADOP 3'h7
// status bits
`define PAC_S_AUX 0
`define PAC_S_REFD 1
`define PAC_S_MOV 2
`define PAC_S_NEG 3
`define PAC_S_PERR 4
// limits and reset values
`define PAC_OVR_MAX 14'h2710
`define PAC_OVR_RST 14'h2710
`define PAC_MV_MAX 15'sh2710
`define PAC_SPO_LIM 4'h3
`define PAC_SPM_REQ 4'h2
`define PAC_CFG_RST 32'h0000_0000
`endif

// ---- pac_pkg.sv ----
// Purpose: types of the axis command unit
// Assumes: nothing
// Notes: constants live in pac_defs.svh
package pac_pkg;
	typedef enum logic [1:0] {PEND_NONE, PEND_START, PEND_STOP, PEND_REF}
		pac_pend_e;
	// motion orders to the axis drive: start, stop, refGo one-cycle; incr, negDir held levels
	typedef struct packed {
		logic start;
		logic stop;
		logic refGo;
		logic incr;
		logic negDir;
	} pac_mot_s;
	typedef struct packed {
		logic [4:0] status;
		logic err;
		logic [2:0] code;
	} pac_res_s;
endpackage

// ---- pac_axis_cmd.sv ----
// Purpose: axis and spindle command unit behind an APB slave
// Assumes: program writes cycle register at end of each scan
// Notes: commands answer at once, motion acts at the scan boundary
// Functional notes
// [RULE_01] stop aborts target move or reference traverse
// [RULE_02] last motion command per axis wins
// [RULE_03] stop codes: 0 ok,1,2,3 stationary
// [RULE_04] error flag set on any nonzero code
// [RULE_05] status word bits aux,ref,moving,neg,error
// [RULE_06] status changes seen from next scan
// [RULE_07] referenced cleared at reset, moving still allowed
// [RULE_08] traverse until mark or stop, then stop
// [RULE_09] traverse flag bit0 selects negative direction
// [RULE_10] traverse enters search, clears reference point
// [RULE_11] traverse clears held positioning error
// [RULE_12] traverse codes: 3 when already positioning
// [RULE_13] only activated and declared axes, else 2
// [RULE_14] override 0..10000, else code 3
// [RULE_15] latest override used, accepted while moving
// [RULE_16] reset or halt sets override 100 percent
// [RULE_17] override applied after same-scan motion
// [RULE_18] analogue output only number 0
// [RULE_19] spindle millivolts clamped to plus minus 10V
// [RULE_20] spindle driven only with valid parameters
// [RULE_21] voltage updated at end of scan
// [RULE_22] axis 0..4 valid, else code 1
// [RULE_23] start cancels search, bit0 incremental
// [RULE_24] per-axis pending command run at boundary
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "pac_defs.svh"
module pac_axis_cmd
	import pac_pkg::*;
#(
	parameter int NAX = 5
) (
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// program interruption
	input wire logic progHalt,
	// axis drive side
	input wire logic [NAX-1:0] axMoving,
	input wire logic [NAX-1:0] axDirNeg,
	input wire logic [NAX-1:0] axPosErrEv,
	input wire logic [NAX-1:0] axRefMark,
	output pac_mot_s [NAX-1:0] axCmd,
	output logic [NAX-1:0][31:0] axTarget,
	output logic [NAX-1:0][13:0] axOvr,
	// spindle analogue output
	output logic signed [14:0] spindleMv,
	output logic spindleValid
);
	initial begin
		if (NAX < 1 || NAX > 8)
			$error("NAX must be 1..8");
	end
	////////////////////////////////////////////////////////////////////
	// state
	logic [31:0] data_ff, cfg_ff;
	pac_res_s res_ff;
	pac_pend_e [NAX-1:0] pend_ff;
	logic [NAX-1:0] pendFlg_ff, pendOvrV_ff, ovrCommit_ff;
	logic [NAX-1:0][13:0] pendOvr_ff;
	logic [NAX-1:0] refd_ff, refSearch_ff, posErr_ff;
	logic [NAX-1:0][4:0] statSnap_ff;
	logic pendAna_ff;
	logic signed [14:0] pendMv_ff;
	////////////////////////////////////////////////////////////////////
	// decode
	logic acc, wr, cmdWr, cycWr, mapped, axOk, cfgOk, spOk;
	logic [2:0] op, ax, code;
	logic flg;
	logic [NAX-1:0] act, aux;
	assign acc = psel & penable & ce;
	assign wr = acc & pwrite;
	assign cmdWr = wr && paddr == `PAC_A_CMD;
	assign cycWr = wr && paddr == `PAC_A_CYC;
	assign op = pwdata[`PAC_F_OP +: 3];
	assign ax = pwdata[`PAC_F_AX +: 3];
	assign flg = pwdata[`PAC_F_FLG];
	assign act = cfg_ff[`PAC_F_ACT +: NAX];
	assign aux = cfg_ff[`PAC_F_AUX +: NAX];
	assign axOk = 32'(ax) < NAX; // [RULE_22]
	assign cfgOk = axOk && act[ax] && aux[ax]; // [RULE_13]
	// [RULE_20]
	assign spOk = cfg_ff[`PAC_F_SPO +: 4] < `PAC_SPO_LIM
		&& cfg_ff[`PAC_F_SPM +: 4] == `PAC_SPM_REQ;
	assign mapped = paddr == `PAC_A_CMD || paddr == `PAC_A_DATA
		|| paddr == `PAC_A_RES || paddr == `PAC_A_CYC
		|| paddr == `PAC_A_CFG;
	// access and configuration checks shared by axis commands
	function automatic logic [2:0] axCode(input logic ok,
		input logic cf);
		if (!ok)
			return `PAC_C_NOAX;
		if (!cf)
			return `PAC_C_NOCFG;
		return `PAC_C_OK;
	endfunction
	// saturate to the spindle range
	function automatic logic signed [14:0] clampMv(
		input logic signed [31:0] v);
		if (v > 32'(`PAC_MV_MAX))
			return `PAC_MV_MAX;
		if (v < -32'(`PAC_MV_MAX))
			return -`PAC_MV_MAX;
		return v[14:0];
	endfunction
	// live status word of one axis
	function automatic logic [4:0] liveStat(input int i);
		logic [4:0] s;
		s = '0;
		s[`PAC_S_AUX] = act[i] & aux[i];
		s[`PAC_S_REFD] = refd_ff[i];
		s[`PAC_S_MOV] = axMoving[i];
		s[`PAC_S_NEG] = axDirNeg[i];
		s[`PAC_S_PERR] = posErr_ff[i];
		return s;
	endfunction
	////////////////////////////////////////////////////////////////////
	// command result, computed in the write cycle
	always_comb begin
		code = axCode(axOk, cfgOk);
		case (op)
		`PAC_OP_START, `PAC_OP_REF: begin
			if (code == `PAC_C_OK && axMoving[ax])
				code = `PAC_C_STATE; // [RULE_12]
		end
		`PAC_OP_STOP: begin
			if (code == `PAC_C_OK && !axMoving[ax])
				code = `PAC_C_STATE; // [RULE_03]
		end
		`PAC_OP_STAT: begin
			code = axOk ? `PAC_C_OK : `PAC_C_NOAX;
		end
		`PAC_OP_OVR: begin
			if (code == `PAC_C_OK && (data_ff[31]
				|| data_ff > 32'(`PAC_OVR_MAX)))
				code = `PAC_C_STATE; // [RULE_14]
		end
		`PAC_OP_ANA: begin
			// [RULE_18]
			if (ax != 3'h0)
				code = `PAC_C_NOAX;
			else if (!spOk)
				code = `PAC_C_NOCFG;
			else
				code = `PAC_C_OK;
		end
		default: code = `PAC_C_BADOP;
		endcase
	end
	////////////////////////////////////////////////////////////////////
	// apb slave: zero wait, ce low stretches the access
	assign pready = ce;
	assign pslverr = acc & ~mapped;
	always_comb begin
		case (paddr)
		`PAC_A_DATA: prdata = data_ff;
		`PAC_A_RES: prdata = {23'h0, res_ff};
		`PAC_A_CFG: prdata = cfg_ff;
		default: prdata = 32'h0;
		endcase
	end
	// software registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			data_ff <= 32'h0;
			cfg_ff <= `PAC_CFG_RST;
		end else if (wr && paddr == `PAC_A_DATA) begin
			data_ff <= pwdata;
		end else if (wr && paddr == `PAC_A_CFG) begin
			cfg_ff <= pwdata;
		end
	end
	// result and flag after every command
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			res_ff <= '0;
		end else if (cmdWr) begin
			res_ff.code <= code;
			res_ff.err <= code != `PAC_C_OK; // [RULE_04]
			// [RULE_05]
			res_ff.status <= (op == `PAC_OP_STAT && axOk)
				? statSnap_ff[ax] : 5'h0;
		end
	end
	////////////////////////////////////////////////////////////////////
	// pending commands per axis, later ones overwrite earlier
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pend_ff <= '{default: PEND_NONE};
			pendFlg_ff <= '0;
			axTarget <= '0;
		end else if (ce) begin
			if (cycWr)
				pend_ff <= '{default: PEND_NONE}; // [RULE_24]
			else if (cmdWr && code == `PAC_C_OK) begin
				case (op)
				`PAC_OP_START: begin
					pend_ff[ax] <= PEND_START; // [RULE_02]
					axTarget[ax] <= data_ff;
				end
				`PAC_OP_STOP: pend_ff[ax] <= PEND_STOP; // [RULE_02]
				`PAC_OP_REF: pend_ff[ax] <= PEND_REF; // [RULE_02]
				default: ;
				endcase
				if (op == `PAC_OP_START || op == `PAC_OP_REF)
					pendFlg_ff[ax] <= flg;
			end
		end
	end
	// motion orders issued at the boundary, plus stop at mark
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			axCmd <= '0;
		end else if (ce) begin
			for (int i = 0; i < NAX; i++) begin
				axCmd[i].start <= cycWr && pend_ff[i] == PEND_START;
				// [RULE_01] [RULE_08]
				axCmd[i].stop <= (cycWr && pend_ff[i] == PEND_STOP)
					|| (refSearch_ff[i] && axRefMark[i]);
				axCmd[i].refGo <= cycWr && pend_ff[i] == PEND_REF;
				axCmd[i].incr <= pendFlg_ff[i]; // [RULE_23]
				axCmd[i].negDir <= pendFlg_ff[i]; // [RULE_09]
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	// reference search, referenced and error flags
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			refd_ff <= '0; // [RULE_07]
			refSearch_ff <= '0;
			posErr_ff <= '0;
		end else if (ce) begin
			for (int i = 0; i < NAX; i++) begin
				if (cycWr && pend_ff[i] == PEND_REF) begin
					refSearch_ff[i] <= 1'b1; // [RULE_10]
					refd_ff[i] <= 1'b0; // [RULE_10]
				end else if (cycWr && pend_ff[i] != PEND_NONE) begin
					refSearch_ff[i] <= 1'b0; // [RULE_23]
				end else if (refSearch_ff[i] && axRefMark[i]) begin
					refSearch_ff[i] <= 1'b0; // [RULE_08]
					refd_ff[i] <= 1'b1;
				end
				// error event wins over the clear
				if (axPosErrEv[i])
					posErr_ff[i] <= 1'b1;
				else if (cycWr && (pend_ff[i] == PEND_REF
					|| pend_ff[i] == PEND_START))
					posErr_ff[i] <= 1'b0; // [RULE_11]
			end
		end
	end
	// status frozen per scan so same-scan effects stay hidden
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			statSnap_ff <= '0;
		end else if (ce && cycWr) begin
			for (int i = 0; i < NAX; i++)
				statSnap_ff[i] <= liveStat(i); // [RULE_06]
		end
	end
	////////////////////////////////////////////////////////////////////
	// override: taken any time, committed a cycle after the
	// motion orders so the drive sees the move first
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pendOvr_ff <= '0;
			pendOvrV_ff <= '0;
			ovrCommit_ff <= '0;
			axOvr <= '{default: `PAC_OVR_RST}; // [RULE_16]
		end else if (ce) begin
			ovrCommit_ff <= cycWr ? pendOvrV_ff : '0;
			if (cycWr)
				pendOvrV_ff <= '0;
			else if (cmdWr && op == `PAC_OP_OVR
				&& code == `PAC_C_OK) begin
				pendOvrV_ff[ax] <= 1'b1; // [RULE_15]
				pendOvr_ff[ax] <= data_ff[13:0];
			end
			for (int i = 0; i < NAX; i++) begin
				if (progHalt)
					axOvr[i] <= `PAC_OVR_RST; // [RULE_16]
				else if (ovrCommit_ff[i])
					axOvr[i] <= pendOvr_ff[i]; // [RULE_17]
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	// spindle voltage, driven only after the scan ends
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pendAna_ff <= 1'b0;
			pendMv_ff <= '0;
			spindleMv <= '0;
			spindleValid <= 1'b0;
		end else if (ce) begin
			if (cycWr) begin
				pendAna_ff <= 1'b0;
				if (pendAna_ff && spOk)
					spindleMv <= pendMv_ff; // [RULE_21]
			end else if (cmdWr && op == `PAC_OP_ANA
				&& code == `PAC_C_OK) begin
				pendAna_ff <= 1'b1;
				pendMv_ff <= clampMv(data_ff); // [RULE_19]
			end
			spindleValid <= spOk; // [RULE_20]
		end
	end
	////////////////////////////////////////////////////////////////////
	// checks
	property p_stop_code;
		@(posedge clk_sys) disable iff (!rstn)
		cmdWr && op == `PAC_OP_STOP && cfgOk && !axMoving[ax]
			|=> res_ff.code == `PAC_C_STATE;
	endproperty
	a_stop_code: assert property (p_stop_code) // [RULE_03]
		else $error("stop on idle axis not code 3");
	property p_err_flag;
		@(posedge clk_sys) disable iff (!rstn)
		cmdWr |=> res_ff.err == (res_ff.code != 3'h0);
	endproperty
	a_err_flag: assert property (p_err_flag) // [RULE_04]
		else $error("error flag mismatches code");
	property p_no_axis;
		@(posedge clk_sys) disable iff (!rstn)
		cmdWr && !axOk && op != `PAC_OP_ANA && op <= `PAC_OP_OVR
			|=> res_ff.code == `PAC_C_NOAX;
	endproperty
	a_no_axis: assert property (p_no_axis) // [RULE_22]
		else $error("bad axis not code 1");
	property p_ovr_range;
		@(posedge clk_sys) disable iff (!rstn)
		cmdWr && op == `PAC_OP_OVR && cfgOk
			&& data_ff > 32'h2710 |=> res_ff.code == 3'h3;
	endproperty
	a_ovr_range: assert property (p_ovr_range) // [RULE_14]
		else $error("override over range accepted");
	property p_ovr_halt;
		@(posedge clk_sys) disable iff (!rstn || !ce)
		progHalt |=> axOvr[0] == 14'h2710;
	endproperty
	a_ovr_halt: assert property (p_ovr_halt) // [RULE_16]
		else $error("override not 100 percent after halt");
	property p_ovr_late;
		@(posedge clk_sys) disable iff (!rstn || !ce)
		cycWr && pendOvrV_ff[0] && !progHalt
			|=> $stable(axOvr[0]) ##1 axOvr[0] == $past(pendOvr_ff[0], 2);
	endproperty
	a_ovr_late: assert property (p_ovr_late) // [RULE_17]
		else $error("override not applied after motion");
	property p_ref_stop;
		@(posedge clk_sys) disable iff (!rstn || !ce)
		refSearch_ff[0] && axRefMark[0] && !cycWr
			|=> axCmd[0].stop && refd_ff[0] && !refSearch_ff[0];
	endproperty
	a_ref_stop: assert property (p_ref_stop) // [RULE_08]
		else $error("reference mark did not stop axis");
	property p_ref_go;
		@(posedge clk_sys) disable iff (!rstn || !ce)
		cycWr && pend_ff[0] == PEND_REF && !axPosErrEv[0]
			|=> axCmd[0].refGo && !refd_ff[0] && !posErr_ff[0];
	endproperty
	a_ref_go: assert property (p_ref_go) // [RULE_11]
		else $error("traverse start left stale flags");
	property p_clamp;
		@(posedge clk_sys) disable iff (!rstn)
		spindleMv <= 15'sh2710 && spindleMv >= -15'sh2710;
	endproperty
	a_clamp: assert property (p_clamp) // [RULE_19]
		else $error("spindle voltage out of range");
	property p_ana_gate;
		@(posedge clk_sys) disable iff (!rstn)
		spindleMv != $past(spindleMv) |-> $past(spOk && cycWr);
	endproperty
	a_ana_gate: assert property (p_ana_gate) // [RULE_20]
		else $error("spindle changed without valid setup");
	property p_snap;
		@(posedge clk_sys) disable iff (!rstn)
		!cycWr |=> statSnap_ff == $past(statSnap_ff);
	endproperty
	a_snap: assert property (p_snap) // [RULE_06]
		else $error("status changed inside a scan");
	c_stop: cover property (@(posedge clk_sys) axCmd[0].stop);
	c_refd: cover property (@(posedge clk_sys) $rose(refd_ff[0]));
	c_ovr: cover property (@(posedge clk_sys) ovrCommit_ff[0]);
	c_ana: cover property (@(posedge clk_sys) $changed(spindleMv));
endmodule

// ---- pac_axis_model.sv ----
// Purpose: behavioural axis drive answering the unit's motion orders
// Assumes: orders are one-cycle pulses in axCmd
// Notes: never reports a positioning error
`timescale 1ns/1ps
module pac_axis_model
	import pac_pkg::*;
#(
	parameter int NAX = 5,
	parameter int MOVE_LEN = 200,
	parameter int REF_LEN = 60
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// orders from the unit
	input wire pac_mot_s [NAX-1:0] axCmd,
	// drive feedback
	output logic [NAX-1:0] axMoving,
	output logic [NAX-1:0] axDirNeg,
	output logic [NAX-1:0] axPosErrEv,
	output logic [NAX-1:0] axRefMark
);
////////////////////////////////////////////////////////////////////////////
logic [NAX-1:0] hunt;
logic [NAX-1:0] neg;
int cnt [NAX];
// a search keeps moving past the mark until the unit orders a stop
always_ff @(posedge clk_sys or negedge rstn) begin
	if (!rstn) begin
		axMoving <= '0;
		hunt <= '0;
		neg <= '0;
		axRefMark <= '0;
		for (int i = 0; i < NAX; i++) cnt[i] <= 0;
	end else begin
		for (int i = 0; i < NAX; i++) begin
			axRefMark[i] <= hunt[i] && cnt[i] == 1;
			if (cnt[i] > 0) cnt[i] <= cnt[i] - 1;
			if (axCmd[i].stop) begin
				axMoving[i] <= 1'b0;
				hunt[i] <= 1'b0;
				cnt[i] <= 0;
			end else if (axCmd[i].start || axCmd[i].refGo) begin
				axMoving[i] <= 1'b1;
				hunt[i] <= axCmd[i].refGo;
				neg[i] <= axCmd[i].negDir;
				cnt[i] <= axCmd[i].refGo ? REF_LEN : MOVE_LEN;
			end else if (cnt[i] == 1 && !hunt[i]) begin
				axMoving[i] <= 1'b0;
			end
		end
	end
end
// direction only means something while moving
assign axDirNeg = axMoving & neg;
assign axPosErrEv = '0;
endmodule

// ---- plc_axis_command_unit_tb_top.sv ----
// Purpose: self-checking bench of the axis command unit
// Assumes: zero-wait APB slave, scan ends with a cycle write
// Notes: pulses on axCmd are counted at falling edges
`timescale 1ns/1ps
`include "pac_defs.svh"
`define CHK(nm, e, s) begin checkCount++; if ((s) !== (e)) begin \
	errCount++; $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module plc_axis_command_unit_tb_top
	import pac_pkg::*;
;
////////////////////////////////////////////////////////////////////////////
logic clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1, progHalt = 1'b0;
logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, se;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0, prdata, r;
logic [4:0] axMoving, axDirNeg, axPosErrEv, axRefMark;
pac_mot_s [4:0] axCmd;
logic [4:0][31:0] axTarget;
logic [4:0][13:0] axOvr;
logic signed [14:0] spindleMv;
logic spindleValid;
int errCount = 0, checkCount = 0;
int nStart [5], nRef [5], nStop [5];
logic [4:0] lastNeg;
always #5 clk_sys = ~clk_sys;
pac_axis_cmd #(.NAX(5)) i_dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.progHalt(progHalt), .axMoving(axMoving), .axDirNeg(axDirNeg),
	.axPosErrEv(axPosErrEv), .axRefMark(axRefMark), .axCmd(axCmd),
	.axTarget(axTarget), .axOvr(axOvr), .spindleMv(spindleMv),
	.spindleValid(spindleValid));
pac_axis_model #(.NAX(5)) i_drv (.clk_sys(clk_sys), .rstn(rstn),
	.axCmd(axCmd), .axMoving(axMoving), .axDirNeg(axDirNeg),
	.axPosErrEv(axPosErrEv), .axRefMark(axRefMark));
// pulses last one cycle, so the falling edge sees each exactly once
always @(negedge clk_sys) begin
	for (int i = 0; i < 5; i++) begin
		if (axCmd[i].start === 1'b1) nStart[i]++;
		if (axCmd[i].stop === 1'b1) nStop[i]++;
		if (axCmd[i].refGo === 1'b1) begin
			nRef[i]++;
			lastNeg[i] = axCmd[i].negDir;
		end
	end
end
////////////////////////////////////////////////////////////////////////////
// one APB transfer; an idle edge before it keeps drivers single per step
task automatic apb(input logic w, input logic [7:0] a,
	input logic [31:0] d, output logic [31:0] q, output logic e);
	@(posedge clk_sys);
	psel <= 1'b1;
	paddr <= a;
	pwrite <= w;
	pwdata <= d;
	@(posedge clk_sys);
	penable <= 1'b1;
	// only the watchdog ends a wait that never sees pready
	do begin
		@(posedge clk_sys);
	end while (pready !== 1'b1);
	q = prdata;
	e = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
endtask
// operand, command, then result word
task automatic cmd(input logic [2:0] op, input logic [2:0] ax,
	input logic flg, input logic [31:0] d, input logic [2:0] ec);
	apb(1'b1, `PAC_A_DATA, d, r, se);
	apb(1'b1, `PAC_A_CMD, {23'h0, flg, 1'b0, ax, 1'b0, op}, r, se);
	apb(1'b0, `PAC_A_RES, 32'h0, r, se);
	`CHK("code", ec, r[2:0])
	`CHK("errflag", (ec != 3'h0), r[3])
endtask
// scan boundary; returns once the override commit has landed
task automatic cyc();
	apb(1'b1, `PAC_A_CYC, 32'h1, r, se);
	repeat (3) @(negedge clk_sys);
endtask
task automatic conclude();
	$display("checks %0d mismatches %0d", checkCount, errCount);
	if (errCount == 0 && checkCount > 0) begin
		$display("Finished cleanly");
	end else begin
		$display("Finished with errors");
	end
	$finish;
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
	#200us;
	errCount++;
	conclude();
end
initial begin
	repeat (4) @(posedge clk_sys);
	rstn <= 1'b1;
	`CHK("ovrRst", 14'h2710, axOvr[0])
	apb(1'b0, `PAC_A_CFG, 32'h0, r, se);
	`CHK("cfgRst", `PAC_CFG_RST, r)
	apb(1'b1, `PAC_A_CFG, 32'h0201_070f, r, se);
	apb(1'b0, `PAC_A_CFG, 32'h0, r, se);
	`CHK("cfg", 32'h0201_070f, r)
	apb(1'b0, 8'h20, 32'h0, r, se);
	`CHK("unmapped", 1'b1, se)
	cyc();
	cmd(`PAC_OP_STAT, 3'h0, 1'b0, 32'h0, `PAC_C_OK);
	`CHK("stat0", 5'h01, r[8:4])
	cmd(`PAC_OP_STOP, 3'h0, 1'b0, 32'h0, `PAC_C_STATE);
	cmd(`PAC_OP_STOP, 3'h5, 1'b0, 32'h0, `PAC_C_NOAX);
	cmd(`PAC_OP_STOP, 3'h7, 1'b0, 32'h0, `PAC_C_NOAX);
	cmd(`PAC_OP_STOP, 3'h3, 1'b0, 32'h0, `PAC_C_NOCFG);
	cmd(`PAC_OP_REF, 3'h4, 1'b0, 32'h0, `PAC_C_NOCFG);
	cmd(`PAC_OP_STAT, 3'h6, 1'b0, 32'h0, `PAC_C_NOAX);
	cmd(`PAC_OP_OVR, 3'h0, 1'b0, 32'd10001, `PAC_C_STATE);
	cmd(`PAC_OP_OVR, 3'h0, 1'b0, 32'hffff_ffff, `PAC_C_STATE);
	cmd(`PAC_OP_OVR, 3'h3, 1'b0, 32'd500, `PAC_C_NOCFG);
	cmd(`PAC_OP_OVR, 3'h0, 1'b0, 32'd1234, `PAC_C_OK);
	cmd(`PAC_OP_START, 3'h1, 1'b0, 32'h100, `PAC_C_OK);
	cmd(`PAC_OP_REF, 3'h1, 1'b1, 32'h0, `PAC_C_OK);
	cyc();
	`CHK("nStart1", 0, nStart[1])
	`CHK("nRef1", 1, nRef[1])
	`CHK("negDir", 1'b1, lastNeg[1])
	`CHK("ovr0", 14'd1234, axOvr[0])
	cmd(`PAC_OP_STAT, 3'h1, 1'b0, 32'h0, `PAC_C_OK);
	`CHK("statOld", 5'h01, r[8:4])
	cyc();
	cmd(`PAC_OP_STAT, 3'h1, 1'b0, 32'h0, `PAC_C_OK);
	`CHK("statMov", 5'h0d, r[8:4])
	cmd(`PAC_OP_REF, 3'h1, 1'b0, 32'h0, `PAC_C_STATE);
	cmd(`PAC_OP_OVR, 3'h1, 1'b0, 32'd0, `PAC_C_OK);
	repeat (70) @(posedge clk_sys);
	cyc();
	`CHK("markStop", 1, nStop[1])
	cmd(`PAC_OP_STAT, 3'h1, 1'b0, 32'h0, `PAC_C_OK);
	`CHK("statRef", 5'h03, r[8:4])
	cmd(`PAC_OP_START, 3'h0, 1'b0, 32'h1234, `PAC_C_OK);
	cyc();
	`CHK("target", 32'h1234, axTarget[0])
	`CHK("nStart0", 1, nStart[0])
	cyc();
	cmd(`PAC_OP_STOP, 3'h0, 1'b0, 32'h0, `PAC_C_OK);
	cyc();
	`CHK("nStop0", 1, nStop[0])
	cmd(`PAC_OP_ANA, 3'h1, 1'b0, 32'd5, `PAC_C_NOAX);
	cmd(`PAC_OP_ANA, 3'h0, 1'b0, 32'd20000, `PAC_C_OK);
	cyc();
	`CHK("mvHi", `PAC_MV_MAX, spindleMv)
	`CHK("mvOn", 1'b1, spindleValid)
	cmd(`PAC_OP_ANA, 3'h0, 1'b0, -32'sd20000, `PAC_C_OK);
	cyc();
	`CHK("mvLo", -`PAC_MV_MAX, spindleMv)
	apb(1'b1, `PAC_A_CFG, 32'h0101_070f, r, se);
	cmd(`PAC_OP_ANA, 3'h0, 1'b0, 32'd5, `PAC_C_NOCFG);
	cmd(3'h6, 3'h0, 1'b0, 32'h0, `PAC_C_BADOP);
	@(posedge clk_sys);
	progHalt <= 1'b1;
	repeat (3) @(negedge clk_sys);
	`CHK("ovrHalt", 14'h2710, axOvr[0])
	conclude();
end
endmodule
